// [hdl/ehm_core.sv]
/*
 * Even half-word vector multiply datapath with accumulator, overflow flags,
 * Wishbone status/mask registers and one level interrupt.
 * Assumes decode presents one operation per issue_i pulse, synchronous to clk_i.
 */
// Function
// [RL1] Unsigned guarded negative accumulate, 64-bit wrap
// [RL2] Guarded forms wrap, flags left untouched
// [RL3] Fractional products shifted, destination only
// [RL4] Fractional products to destination and accumulator
// [RL5] Fractional add into accumulator words
// [RL6] Fractional subtract from accumulator words
// [RL7] Integer products to destination only
// [RL8] Integer products copied to accumulator
// [RL9] Integer add into accumulator words
// [RL10] Integer subtract from accumulator words
// [RL11] Minus one squared saturates to max fraction
// [RL12] Lane flags written, sticky flags ORed
// [RL13] Decode supplies opcode 4 and fields
// [RL14] Operands from bits 0-15 and 32-47
`timescale 1ns/1ps
module ehm_core (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Decode issue
   input wire logic issue_i,
   input wire logic [5:0] primary_op_i,
   input wire logic [4:0] rd_idx_i,
   input wire logic [10:0] ext_op_i,
   input wire logic [63:0] src_a_i,
   input wire logic [63:0] src_b_i,
   // Result
   output logic res_valid_o,
   output logic [4:0] res_rd_o,
   output logic [63:0] res_data_o,
   output logic illegal_o,
   output logic [63:0] vector_accumulator_o,
   output logic low_lane_overflow_flag_o,
   output logic high_lane_overflow_o,
   output logic low_lane_sticky_overflow_o,
   output logic high_lane_sticky_overflow_o,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Interrupt
   output logic irq_o
);
   typedef struct packed {
      logic [63:0] acc;
      logic [63:0] res;
      logic [4:0] rd;
      logic vld;
      logic ill;
      logic [5:0] stat;
      logic [5:0] mask;
      logic [31:0] rdat;
      logic ack;
      logic irq;
   } ehm_state_t;

   ehm_state_t st_r;
   ehm_state_t st_nxt;

   logic [15:0] ah, al, bh, bl;
   logic signed [31:0] ph, pl;
   logic [31:0] pu;
   logic [32:0] fh, fl;
   logic movh, movl;
   logic [31:0] frh, frl, sth, stl;
   logic [64:0] gdiff;
   logic [63:0] gext;
   logic [32:0] wh, wl;
   logic legal;
   logic sat_op;
   logic ovh_new, ovl_new;

   localparam int HI_LANE_LSB_S = ehm_pkg::HI_LANE_LSB;
   localparam int LO_LANE_LSB_S = ehm_pkg::LO_LANE_LSB;

   always_comb begin
      // Even half-words of each lane [RL14]
      ah = src_a_i[HI_LANE_LSB_S +: 16];
      al = src_a_i[LO_LANE_LSB_S +: 16];
      bh = src_b_i[HI_LANE_LSB_S +: 16];
      bl = src_b_i[LO_LANE_LSB_S +: 16];
   end

   always_comb begin
      ph = $signed(ah) * $signed(bh);
      pl = $signed(al) * $signed(bl);
      pu = al * bl;
      fh = {ph, 1'b0}; // [RL3]
      fl = {pl, 1'b0};
      movh = fh[32] ^ fh[31]; // [RL11]
      movl = fl[32] ^ fl[31];
      frh = fh[31:0];
      frl = fl[31:0];
      sth = movh ? ehm_pkg::MAX_FRAC : frh; // [RL11]
      stl = movl ? ehm_pkg::MAX_FRAC : frl;
   end

   always_comb begin
      st_nxt = st_r;
      legal = 1'b1;
      sat_op = 1'b0;
      gext = 64'h0;
      gdiff = 65'h0;
      wh = 33'h0;
      wl = 33'h0;
      ovh_new = 1'b0;
      ovl_new = 1'b0;
      st_nxt.vld = 1'b0;
      st_nxt.ill = 1'b0;
      st_nxt.ack = 1'b0;
      if (issue_i) begin
         st_nxt.vld = 1'b1;
         st_nxt.rd = rd_idx_i;
         legal = (primary_op_i == ehm_pkg::PRIMARY_OP); // [RL13]
         if (legal) begin
            case (ext_op_i)
               ehm_pkg::XO_GUMIAN, ehm_pkg::XO_GUMIAA: begin
                  gext = {32'h0, pu};
                  gdiff = (ext_op_i == ehm_pkg::XO_GUMIAN) ? {1'b0, st_r.acc} - {1'b0, gext}
                                                          : {1'b0, st_r.acc} + {1'b0, gext}; // [RL1]
               end
               ehm_pkg::XO_GSMFAA, ehm_pkg::XO_GSMFAN: begin
                  gext = {{31{fl[32]}}, fl};
                  gdiff = (ext_op_i == ehm_pkg::XO_GSMFAN) ? {1'b0, st_r.acc} - {1'b0, gext}
                                                          : {1'b0, st_r.acc} + {1'b0, gext};
               end
               ehm_pkg::XO_GSMIAA, ehm_pkg::XO_GSMIAN: begin
                  gext = {{32{pl[31]}}, pl};
                  gdiff = (ext_op_i == ehm_pkg::XO_GSMIAN) ? {1'b0, st_r.acc} - {1'b0, gext}
                                                          : {1'b0, st_r.acc} + {1'b0, gext};
               end
               ehm_pkg::XO_SMF, ehm_pkg::XO_SMFA: begin
                  st_nxt.res = {frh, frl}; // [RL3]
                  if (ext_op_i == ehm_pkg::XO_SMFA) st_nxt.acc = {frh, frl}; // [RL4]
               end
               ehm_pkg::XO_SMFAAW, ehm_pkg::XO_SMFANW: begin
                  if (ext_op_i == ehm_pkg::XO_SMFAAW) begin
                     wh = {1'b0, st_r.acc[63:32]} + {1'b0, frh}; // [RL5]
                     wl = {1'b0, st_r.acc[31:0]} + {1'b0, frl};
                  end else begin
                     wh = {1'b0, st_r.acc[63:32]} - {1'b0, frh}; // [RL6]
                     wl = {1'b0, st_r.acc[31:0]} - {1'b0, frl};
                  end
                  st_nxt.res = {wh[31:0], wl[31:0]};
                  st_nxt.acc = {wh[31:0], wl[31:0]};
               end
               ehm_pkg::XO_SMI, ehm_pkg::XO_SMIA: begin
                  st_nxt.res = {ph, pl}; // [RL7]
                  if (ext_op_i == ehm_pkg::XO_SMIA) st_nxt.acc = {ph, pl}; // [RL8]
               end
               ehm_pkg::XO_SMIAAW, ehm_pkg::XO_SMIANW: begin
                  if (ext_op_i == ehm_pkg::XO_SMIAAW) begin
                     wh = {1'b0, st_r.acc[63:32]} + {1'b0, ph}; // [RL9]
                     wl = {1'b0, st_r.acc[31:0]} + {1'b0, pl};
                  end else begin
                     wh = {1'b0, st_r.acc[63:32]} - {1'b0, ph}; // [RL10]
                     wl = {1'b0, st_r.acc[31:0]} - {1'b0, pl};
                  end
                  st_nxt.res = {wh[31:0], wl[31:0]};
                  st_nxt.acc = {wh[31:0], wl[31:0]};
               end
               ehm_pkg::XO_SSF, ehm_pkg::XO_SSFA: begin
                  sat_op = 1'b1;
                  ovh_new = movh;
                  ovl_new = movl;
                  st_nxt.res = {sth, stl}; // [RL11]
                  if (ext_op_i == ehm_pkg::XO_SSFA) st_nxt.acc = {sth, stl};
               end
               default: legal = 1'b0;
            endcase
            // Guarded forms: low 64 bits, flags untouched [RL2]
            if (gext != 64'h0 || ext_op_i inside {ehm_pkg::XO_GUMIAN, ehm_pkg::XO_GUMIAA,
                ehm_pkg::XO_GSMFAA, ehm_pkg::XO_GSMFAN, ehm_pkg::XO_GSMIAA, ehm_pkg::XO_GSMIAN}) begin
               st_nxt.res = gdiff[63:0];
               st_nxt.acc = gdiff[63:0];
            end
         end
         st_nxt.ill = ~legal;
         // Refused ops raise no result strobe
         st_nxt.vld = legal;
         if (sat_op) begin
            // Lane flags overwritten, sticky flags only set [RL12]
            st_nxt.stat[ehm_pkg::BIT_OVH] = ovh_new;
            st_nxt.stat[ehm_pkg::BIT_OVL] = ovl_new;
            st_nxt.stat[ehm_pkg::BIT_HI_STICKY] = st_r.stat[ehm_pkg::BIT_HI_STICKY] | ovh_new;
            st_nxt.stat[ehm_pkg::BIT_LO_STICKY] = st_r.stat[ehm_pkg::BIT_LO_STICKY] | ovl_new;
         end
      end
      // Wishbone: one wait state, ack for one cycle
      if (wb_cyc_i && wb_stb_i && !st_r.ack) begin
         st_nxt.ack = 1'b1;
         st_nxt.rdat = 32'h0;
         if (wb_adr_i == ehm_pkg::OFS_ACC_HI) st_nxt.rdat = st_r.acc[63:32];
         else if (wb_adr_i == ehm_pkg::OFS_ACC_LO) st_nxt.rdat = st_r.acc[31:0];
         else if (wb_adr_i == ehm_pkg::OFS_STATUS) st_nxt.rdat = {26'h0, st_r.stat};
         else if (wb_adr_i == ehm_pkg::OFS_MASK) st_nxt.rdat = {26'h0, st_r.mask};
      end
      // Mask write lands at the edge that sees ack, as the master expects
      if (wb_cyc_i && wb_stb_i && st_r.ack && wb_we_i && wb_sel_i[0] && wb_adr_i == ehm_pkg::OFS_MASK)
         st_nxt.mask = wb_dat_i[5:0];
      // Only events already returned are cleared, so none is lost; a same-cycle set wins
      if (wb_cyc_i && wb_stb_i && st_r.ack && !wb_we_i && wb_adr_i == ehm_pkg::OFS_STATUS)
         st_nxt.stat[ehm_pkg::BIT_EVT_ILL:ehm_pkg::BIT_EVT_SAT] =
            st_r.stat[ehm_pkg::BIT_EVT_ILL:ehm_pkg::BIT_EVT_SAT] &
            ~st_r.rdat[ehm_pkg::BIT_EVT_ILL:ehm_pkg::BIT_EVT_SAT];
      if (issue_i && sat_op && (ovh_new || ovl_new)) st_nxt.stat[ehm_pkg::BIT_EVT_SAT] = 1'b1;
      if (issue_i && !legal) st_nxt.stat[ehm_pkg::BIT_EVT_ILL] = 1'b1;
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= '0;
         st_r.acc <= ehm_pkg::ACC_RST;
         st_r.mask <= ehm_pkg::MASK_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_comb begin
      res_valid_o = st_r.vld;
      res_rd_o = st_r.rd;
      res_data_o = st_r.res;
      illegal_o = st_r.ill;
      vector_accumulator_o = st_r.acc;
      high_lane_overflow_o = st_r.stat[ehm_pkg::BIT_OVH];
      low_lane_overflow_flag_o = st_r.stat[ehm_pkg::BIT_OVL];
      high_lane_sticky_overflow_o = st_r.stat[ehm_pkg::BIT_HI_STICKY];
      low_lane_sticky_overflow_o = st_r.stat[ehm_pkg::BIT_LO_STICKY];
      wb_dat_o = st_r.rdat;
      wb_ack_o = st_r.ack;
      irq_o = st_r.irq;
   end

   // Assertions
   property p_gumian; // [RL1]
      @(posedge clk_i) disable iff (!rst_b_i)
      issue_i && primary_op_i == ehm_pkg::PRIMARY_OP && ext_op_i == ehm_pkg::XO_GUMIAN
      |=> res_data_o == $past(st_r.acc) - {32'h0, 32'($past(src_a_i[31:16])) * 32'($past(src_b_i[31:16]))};
   endproperty
   a_gumian: assert property (p_gumian) else $error("unsigned guarded negate wrong");
   property p_guard_flags; // [RL2]
      @(posedge clk_i) disable iff (!rst_b_i)
      issue_i && ext_op_i[10:8] == 3'b101 && ext_op_i[5:4] == 2'b10 |=> $stable(st_r.stat[3:0]);
   endproperty
   a_guard_flags: assert property (p_guard_flags) else $error("guarded form changed flags");
   property p_smf; // [RL3]
      @(posedge clk_i) disable iff (!rst_b_i)
      issue_i && primary_op_i == ehm_pkg::PRIMARY_OP && ext_op_i == ehm_pkg::XO_SMF
      |=> res_data_o[31:0] == {$past(pl[30:0]), 1'b0} && $stable(vector_accumulator_o);
   endproperty
   a_smf: assert property (p_smf) else $error("fractional product wrong");
   property p_smfa; // [RL4]
      @(posedge clk_i) disable iff (!rst_b_i)
      issue_i && primary_op_i == ehm_pkg::PRIMARY_OP && ext_op_i == ehm_pkg::XO_SMFA
      |=> vector_accumulator_o == res_data_o;
   endproperty
   a_smfa: assert property (p_smfa) else $error("accumulator not updated");
   property p_smfaaw; // [RL5]
      @(posedge clk_i) disable iff (!rst_b_i)
      issue_i && primary_op_i == ehm_pkg::PRIMARY_OP && ext_op_i == ehm_pkg::XO_SMFAAW
      |=> res_data_o[31:0] == $past(st_r.acc[31:0]) + $past(frl) && vector_accumulator_o == res_data_o;
   endproperty
   a_smfaaw: assert property (p_smfaaw) else $error("word accumulate wrong");
   property p_smfanw;
      @(posedge clk_i) disable iff (!rst_b_i)
      issue_i && primary_op_i == ehm_pkg::PRIMARY_OP && ext_op_i == ehm_pkg::XO_SMFANW
      |=> res_data_o[63:32] == $past(st_r.acc[63:32]) - $past(frh) && vector_accumulator_o == res_data_o;
   endproperty
   a_smfanw: assert property (p_smfanw) else $error("fractional word negate accumulate wrong"); // [RL6]
   property p_ill_quiet;
      @(posedge clk_i) disable iff (!rst_b_i)
      illegal_o |-> !res_valid_o;
   endproperty
   a_ill_quiet: assert property (p_ill_quiet) else $error("refused op gave a result"); // [RL13]
   property p_smianw; // [RL10]
      @(posedge clk_i) disable iff (!rst_b_i)
      issue_i && primary_op_i == ehm_pkg::PRIMARY_OP && ext_op_i == ehm_pkg::XO_SMIANW
      |=> res_data_o[63:32] == $past(st_r.acc[63:32]) - $past(ph);
   endproperty
   a_smianw: assert property (p_smianw) else $error("word negate accumulate wrong");
   property p_sat; // [RL11]
      @(posedge clk_i) disable iff (!rst_b_i)
      issue_i && primary_op_i == ehm_pkg::PRIMARY_OP && ext_op_i == ehm_pkg::XO_SSF
      && al == 16'h8000 && bl == 16'h8000 |=> res_data_o[31:0] == ehm_pkg::MAX_FRAC && low_lane_overflow_flag_o;
   endproperty
   a_sat: assert property (p_sat) else $error("saturation missing");
   property p_sticky; // [RL12]
      @(posedge clk_i) disable iff (!rst_b_i)
      high_lane_sticky_overflow_o |=> high_lane_sticky_overflow_o;
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky flag cleared");
   property p_ack;
      @(posedge clk_i) disable iff (!rst_b_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack longer than one cycle");
   c_sat: cover property (@(posedge clk_i) disable iff (!rst_b_i) low_lane_overflow_flag_o);
   c_irq: cover property (@(posedge clk_i) disable iff (!rst_b_i) irq_o);
   c_ill: cover property (@(posedge clk_i) disable iff (!rst_b_i) illegal_o);
   c_guard: cover property (@(posedge clk_i) disable iff (!rst_b_i) issue_i && ext_op_i == ehm_pkg::XO_GUMIAN);
endmodule

// [hdl/ehm_pkg.sv]
/*
 * Package for the even half-word vector multiplier: opcodes, field
 * positions, saturation constants, register offsets and reset values.
 * Assumes a 32-bit classic Wishbone master for status and interrupt access.
 */
package ehm_pkg;
   localparam logic [5:0] PRIMARY_OP = 6'h04;
   // Extended opcodes
   localparam logic [10:0] XO_GUMIAN = 11'h5a8;
   localparam logic [10:0] XO_GSMFAA = 11'h52b;
   localparam logic [10:0] XO_GSMFAN = 11'h5ab;
   localparam logic [10:0] XO_GSMIAA = 11'h529;
   localparam logic [10:0] XO_GSMIAN = 11'h5a9;
   localparam logic [10:0] XO_GUMIAA = 11'h528;
   localparam logic [10:0] XO_SMF = 11'h40b;
   localparam logic [10:0] XO_SMFA = 11'h42b;
   localparam logic [10:0] XO_SMFAAW = 11'h50b;
   localparam logic [10:0] XO_SMFANW = 11'h58b;
   localparam logic [10:0] XO_SMI = 11'h409;
   localparam logic [10:0] XO_SMIA = 11'h429;
   localparam logic [10:0] XO_SMIAAW = 11'h509;
   localparam logic [10:0] XO_SMIANW = 11'h589;
   localparam logic [10:0] XO_SSF = 11'h403;
   localparam logic [10:0] XO_SSFA = 11'h423;
   // Operand lanes: high lane bits 0..15 (MSB numbering) = [63:48]
   localparam int HI_LANE_LSB = 48;
   localparam int LO_LANE_LSB = 16;
   localparam logic [31:0] MAX_FRAC = 32'h7fffffff;
   localparam logic [63:0] ACC_RST = 64'h0;
   // Wishbone register byte offsets
   localparam logic [3:0] OFS_ACC_HI = 4'h0;
   localparam logic [3:0] OFS_ACC_LO = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_MASK = 4'hc;
   // Status bit positions
   localparam int BIT_OVH = 0;
   localparam int BIT_OVL = 1;
   localparam int BIT_HI_STICKY = 2;
   localparam int BIT_LO_STICKY = 3;
   localparam int BIT_EVT_SAT = 4;
   localparam int BIT_EVT_ILL = 5;
   localparam logic [5:0] MASK_RST = 6'h00;
   typedef enum logic [1:0] {
      EHM_IDLE = 2'b00,
      EHM_ACK = 2'b01
   } ehm_bus_t;
endpackage

// [verification/ehm_decode_model.sv]
/*
 * Decode-side partner: splits one instruction word into the fields
 * that the datapath takes. Assumes the bench reads the operands itself.
 */
`timescale 1ns/1ps
module ehm_decode_model (
   // Instruction from bench
   input wire logic [31:0] instr_i,
   // Fields to the datapath
   output logic [5:0] primary_op_o,
   output logic [4:0] rd_idx_o,
   output logic [10:0] ext_op_o
);
   // Source fields unused: operands arrive already read
   assign primary_op_o = instr_i[31:26];
   assign rd_idx_o = instr_i[25:21];
   assign ext_op_o = instr_i[10:0];
endmodule

// [verification/ehm_core_test.sv]
/*
 * Self-checking bench for the even half-word multiplier: corner and random
 * operations, status, mask and interrupt over Wishbone. Assumes ehm_pkg.
 */
`timescale 1ns/1ps
module ehm_core_test;
   logic clk = 0, rst_b = 0, issue = 0, cyc = 0, stb = 0, we = 0;
   logic [3:0] adr = 0, sel = 0;
   logic [31:0] wdat = 0, instr = 0, rdat;
   logic [63:0] src_a = 0, src_b = 0, res_data, acc, e_acc = 0, p_res = 0;
   logic [5:0] pri, e_st = 0;
   logic [4:0] rd_idx, res_rd, p_rd = 0;
   logic [10:0] xo;
   logic res_valid, illegal, hi_ovf, lo_ovf, hi_sticky, lo_sticky, ack, irq, p_on = 0, p_ill = 0;
   int compares = 0, fail_count = 0;
   logic [10:0] xo_tab [16] = '{ehm_pkg::XO_GUMIAN, ehm_pkg::XO_GSMFAA, ehm_pkg::XO_GSMFAN,
      ehm_pkg::XO_GSMIAA, ehm_pkg::XO_GSMIAN, ehm_pkg::XO_GUMIAA, ehm_pkg::XO_SMF, ehm_pkg::XO_SMFA,
      ehm_pkg::XO_SMFAAW, ehm_pkg::XO_SMFANW, ehm_pkg::XO_SMI, ehm_pkg::XO_SMIA, ehm_pkg::XO_SMIAAW,
      ehm_pkg::XO_SMIANW, ehm_pkg::XO_SSF, ehm_pkg::XO_SSFA};

   always #2.5 clk = ~clk;

   ehm_decode_model dec (.instr_i(instr), .primary_op_o(pri), .rd_idx_o(rd_idx), .ext_op_o(xo));
   ehm_core dut (.clk_i(clk), .rst_b_i(rst_b), .issue_i(issue), .primary_op_i(pri), .rd_idx_i(rd_idx),
      .ext_op_i(xo), .src_a_i(src_a), .src_b_i(src_b), .res_valid_o(res_valid), .res_rd_o(res_rd),
      .res_data_o(res_data), .illegal_o(illegal), .vector_accumulator_o(acc),
      .low_lane_overflow_flag_o(lo_ovf), .high_lane_overflow_o(hi_ovf),
      .low_lane_sticky_overflow_o(lo_sticky), .high_lane_sticky_overflow_o(hi_sticky),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Returns {high sat, low sat, new accumulator, destination}
   function automatic logic [129:0] model(input logic [10:0] x, input logic [63:0] a, b, c);
      logic signed [31:0] ph, pl;
      logic [32:0] fh, fl;
      logic [31:0] pu;
      logic [63:0] r;
      logic mh, ml;
      ph = $signed(a[63:48]) * $signed(b[63:48]);
      pl = $signed(a[31:16]) * $signed(b[31:16]);
      pu = a[31:16] * b[31:16];
      fh = {ph, 1'b0};
      fl = {pl, 1'b0};
      mh = fh[32] ^ fh[31];
      ml = fl[32] ^ fl[31];
      r = c;
      case (x)
         ehm_pkg::XO_SMF, ehm_pkg::XO_SMFA: r = {fh[31:0], fl[31:0]};
         ehm_pkg::XO_SMI, ehm_pkg::XO_SMIA: r = {ph, pl};
         ehm_pkg::XO_SMFAAW: r = {c[63:32] + fh[31:0], c[31:0] + fl[31:0]};
         ehm_pkg::XO_SMFANW: r = {c[63:32] - fh[31:0], c[31:0] - fl[31:0]};
         ehm_pkg::XO_SMIAAW: r = {c[63:32] + ph, c[31:0] + pl};
         ehm_pkg::XO_SMIANW: r = {c[63:32] - ph, c[31:0] - pl};
         ehm_pkg::XO_SSF, ehm_pkg::XO_SSFA: r = {mh ? ehm_pkg::MAX_FRAC : fh[31:0],
            ml ? ehm_pkg::MAX_FRAC : fl[31:0]};
         ehm_pkg::XO_GSMFAA: r = c + {{31{pl[31]}}, pl, 1'b0};
         ehm_pkg::XO_GSMFAN: r = c - {{31{pl[31]}}, pl, 1'b0};
         ehm_pkg::XO_GSMIAA: r = c + {{32{pl[31]}}, pl};
         ehm_pkg::XO_GSMIAN: r = c - {{32{pl[31]}}, pl};
         ehm_pkg::XO_GUMIAA: r = c + {32'h0, pu};
         ehm_pkg::XO_GUMIAN: r = c - {32'h0, pu};
         default: r = c;
      endcase
      return {mh, ml, (x inside {ehm_pkg::XO_SMF, ehm_pkg::XO_SMI, ehm_pkg::XO_SSF}) ? c : r, r};
   endfunction

   // Results of the op taken at the last edge
   task automatic flush;
      if (p_on) begin
         check("illegal", 64'(illegal), 64'(p_ill));
         check("valid", 64'(res_valid), 64'(!p_ill));
         if (!p_ill) check("rd", 64'(res_rd), 64'(p_rd));
         check("result", res_data, p_res);
         check("acc", acc, e_acc);
         check("flags", 64'({lo_sticky, hi_sticky, lo_ovf, hi_ovf}), 64'(e_st[3:0]));
      end
      p_on = 0;
   endtask

   // Issue stays high across calls, so ops run back to back
   task automatic do_op(input logic [5:0] p, input logic [10:0] x, input logic [63:0] a, b);
      logic [129:0] m;
      logic [4:0] rd;
      rd = 5'($urandom);
      @(posedge clk);
      issue <= 1'b1;
      instr <= {p, rd, 10'h0, x};
      src_a <= a;
      src_b <= b;
      @(negedge clk);
      flush();
      m = model(x, a, b, e_acc);
      p_on = 1;
      p_rd = rd;
      p_ill = p !== ehm_pkg::PRIMARY_OP || !(x inside {xo_tab});
      if (p_ill) begin
         e_st[5] = 1'b1;
      end else begin
         p_res = m[63:0];
         e_acc = m[127:64];
         if (x inside {ehm_pkg::XO_SSF, ehm_pkg::XO_SSFA}) begin
            e_st[1:0] = {m[128], m[129]};
            e_st[3:2] = e_st[3:2] | {m[128], m[129]};
            e_st[4] = e_st[4] | m[128] | m[129];
         end
      end
   endtask

   task automatic idle;
      @(posedge clk);
      issue <= 1'b0;
      @(negedge clk);
      flush();
   endtask

   task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      sel <= 4'hf;
      // No wait limit here: only the watchdog ends a hung access
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic reg_chk(input logic [3:0] ad, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, ad, 32'h0, q);
      check("register", 64'(q), 64'(exp));
   endtask

   initial begin
      logic [31:0] q;
      void'($urandom(38));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      wb(1'b1, ehm_pkg::OFS_MASK, 32'h10, q);
      reg_chk(ehm_pkg::OFS_MASK, 32'h10);
      reg_chk(4'h2, 32'h0);
      // Minus one squared in one lane at a time, then an unsigned guarded subtract
      do_op(ehm_pkg::PRIMARY_OP, ehm_pkg::XO_SSF, 64'h8000000040000000, 64'h8000000080000000);
      do_op(ehm_pkg::PRIMARY_OP, ehm_pkg::XO_SSFA, 64'h0001000080000000, 64'h7fff000080000000);
      do_op(ehm_pkg::PRIMARY_OP, ehm_pkg::XO_GUMIAN, 64'hffff0000ffff0000, 64'hffff0000ffff0000);
      idle();
      repeat (3) @(negedge clk);
      check("irq", 64'(irq), 64'h1);
      reg_chk(ehm_pkg::OFS_STATUS, 32'(e_st));
      e_st[5:4] = 2'b00;
      repeat (3) @(negedge clk);
      check("irq", 64'(irq), 64'h0);
      repeat (200) do_op(ehm_pkg::PRIMARY_OP, xo_tab[$urandom_range(15, 0)], {$urandom, $urandom},
         {$urandom, $urandom});
      // Wrong primary code, then an unsupported form
      do_op(6'h05, ehm_pkg::XO_SMF, 64'h1, 64'h1);
      do_op(ehm_pkg::PRIMARY_OP, 11'h503, 64'h1, 64'h1);
      idle();
      repeat (3) @(negedge clk);
      check("irq masked", 64'(irq), 64'(e_st[4]));
      wb(1'b1, ehm_pkg::OFS_MASK, 32'h20, q);
      repeat (3) @(negedge clk);
      check("irq", 64'(irq), 64'h1);
      reg_chk(ehm_pkg::OFS_STATUS, 32'(e_st));
      reg_chk(ehm_pkg::OFS_ACC_HI, e_acc[63:32]);
      reg_chk(ehm_pkg::OFS_ACC_LO, e_acc[31:0]);
      stop_test();
   end

   // Run needs about 260 cycles
   initial begin
      #20000;
      fail_count++;
      stop_test();
   end
endmodule
